// ### inc/lsp_cfg.svh
`ifndef LSP_CFG_SVH
`define LSP_CFG_SVH
// Field widths
`define LSP_OGF_W 6
`define LSP_OCF_W 10
`define LSP_HANDLE_W 12
`define LSP_STATUS_W 8
`define LSP_VALUE_W 16
`define LSP_BYTE_W 8
// Command group and command fields
`define LSP_OGF_STATUS 6'h05
`define LSP_OCF_READ_MISS 10'h001
`define LSP_OCF_CLEAR_MISS 10'h002
`define LSP_OCF_QUALITY 10'h003
`define LSP_OCF_SIGNAL 10'h005
// Highest usable link handle
`define LSP_HANDLE_MAX 12'heff
// Status codes
`define LSP_ST_OK 8'h00
`define LSP_ST_UNK_CMD 8'h01
`define LSP_ST_NO_LINK 8'h02
// Link table size and counter limits
`define LSP_NSLOT 4
`define LSP_MISS_ZERO 16'h0000
`define LSP_MISS_ONE 16'h0001
`define LSP_MISS_MAX 16'hffff
// Quality derivation: each miss costs this many steps (as a shift)
`define LSP_QUAL_SHIFT 4
`define LSP_QUAL_LIMIT 16'h000f
`define LSP_QUAL_BEST 8'hff
`define LSP_S8_MAX 9'sh07f
`define LSP_S8_MIN -9'sh080
`endif

// ### inc/lsp_pkg.sv
package lsp_pkg;
  `include "lsp_cfg.svh"

  // Host command as received
  typedef struct packed {
    logic [`LSP_OGF_W-1:0] ogf;
    logic [`LSP_OCF_W-1:0] ocf;
    logic [`LSP_HANDLE_W-1:0] handle;
  } lsp_cmd_s;

  // Command-complete event contents
  typedef struct packed {
    logic [`LSP_OGF_W-1:0] ogf;
    logic [`LSP_OCF_W-1:0] ocf;
    logic [`LSP_STATUS_W-1:0] status;
    logic [`LSP_HANDLE_W-1:0] handle;
    logic [`LSP_VALUE_W-1:0] value;
  } lsp_evt_s;

  // Link-side event kinds
  typedef enum logic [2:0] {
    LSP_LNK_CONNECT,
    LSP_LNK_DISCONNECT,
    LSP_LNK_FLUSH,
    LSP_LNK_ACK,
    LSP_LNK_SAMPLE
  } lsp_lnk_e;

  // Link-side event with its handle and strength sample
  typedef struct packed {
    lsp_lnk_e kind;
    logic [`LSP_HANDLE_W-1:0] handle;
    logic signed [`LSP_BYTE_W-1:0] sample;
  } lsp_lnk_s;

  // Command engine states
  typedef enum logic [1:0] {
    LSP_IDLE,
    LSP_EXEC,
    LSP_RESP
  } lsp_state_e;
endpackage : lsp_pkg

// ### logic/lsp_slot.sv
`timescale 1ns/10ps
`include "lsp_cfg.svh"
module lsp_slot (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link events for this slot
  input wire logic connect,
  input wire logic disconnect,
  input wire logic [`LSP_HANDLE_W-1:0] handle_in,
  input wire logic flush,
  input wire logic ack,
  input wire logic clear,
  input wire logic sample_we,
  input wire logic signed [`LSP_BYTE_W-1:0] sample_in,
  // Slot state
  output logic used,
  output logic [`LSP_HANDLE_W-1:0] handle,
  output logic [`LSP_VALUE_W-1:0] count,
  output logic signed [`LSP_BYTE_W-1:0] sample
);
  import lsp_pkg::*;

  // Occupancy and handle of the link held here
  always_ff @(posedge clk) begin
    if (rst) begin
      used <= 1'b0;
      handle <= '0;
    end else if (connect) begin
      used <= 1'b1;
      handle <= handle_in;
    end else if (disconnect) begin
      used <= 1'b0;
    end
  end

  // Consecutive miss count; a miss beats a same-cycle clear so it is never lost
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= `LSP_MISS_ZERO;
    end else if (connect) begin
      count <= `LSP_MISS_ZERO;
    end else if (flush) begin
      // Saturate rather than wrap to zero
      if (count != `LSP_MISS_MAX) begin
        count <= count + `LSP_MISS_ONE;
      end
    end else if (clear) begin
      count <= `LSP_MISS_ZERO;
    end else if (ack && count != `LSP_MISS_ZERO) begin
      count <= `LSP_MISS_ZERO;
    end
  end

  // Latest received-strength sample
  always_ff @(posedge clk) begin
    if (rst || connect) begin
      sample <= '0;
    end else if (sample_we) begin
      sample <= sample_in;
    end
  end

  a_miss_incr: assert property (@(posedge clk) disable iff (rst)
    (flush && !connect && count != `LSP_MISS_MAX) |=> count == $past(count) + `LSP_MISS_ONE)
    else $error("miss count did not step by one");
  a_conn_zero: assert property (@(posedge clk) disable iff (rst)
    connect |=> count == `LSP_MISS_ZERO && used)
    else $error("new link did not start at zero");
  a_ack_zero: assert property (@(posedge clk) disable iff (rst)
    (ack && !flush && !connect && count != `LSP_MISS_ZERO) |=> count == `LSP_MISS_ZERO)
    else $error("acknowledge did not clear the count");
  a_clear_zero: assert property (@(posedge clk) disable iff (rst)
    (clear && !flush && !connect) |=> count == `LSP_MISS_ZERO)
    else $error("clear command did not zero the count");
endmodule : lsp_slot

// ### logic/lsp_status_cmds.sv
// Notes on behaviour
// - Flushed unanswered packet adds one to count
// - New connection zeroes that link's count
// - Acknowledged packet zeroes a nonzero count
// - Clear command zeroes addressed link's count; a same-cycle miss wins, count steps by one instead
// - Read reply carries count as two bytes
// - Handles twelve bits, above 0x0EFF reserved
// - Reply opens with status, zero means success
// - Every reply echoes the addressed handle
// - Completion raises event unless host masked it
// - Quality command returns one byte, higher better
// - Quality derivation is our own choice
// - Strength reply gives dB outside window, else zero
// - Must at least tell inside, above, below
// - All four commands sit in group 0x05
// - Strength value is one signed byte
`timescale 1ns/10ps
`include "lsp_cfg.svh"
module lsp_status_cmds (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Host command port
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire lsp_pkg::lsp_cmd_s CMD,
  // Command-complete event port
  output logic EVT_VALID,
  input wire logic EVT_READY,
  output lsp_pkg::lsp_evt_s EVT,
  input wire logic EVT_MASK,
  // Link-side events
  input wire logic LNK_VALID,
  input wire lsp_pkg::lsp_lnk_s LNK,
  // Reference window limits, signed dB
  input wire logic signed [7:0] WIN_UPPER,
  input wire logic signed [7:0] WIN_LOWER
);
  import lsp_pkg::*;

  lsp_state_e state; // Command engine state
  lsp_cmd_s cmd_q; // Command being served
  logic [`LSP_NSLOT-1:0] used; // Slot occupied
  logic [`LSP_HANDLE_W-1:0] slot_handle [`LSP_NSLOT]; // Handle per slot
  logic [`LSP_VALUE_W-1:0] slot_count [`LSP_NSLOT]; // Miss count per slot
  logic signed [`LSP_BYTE_W-1:0] slot_sample [`LSP_NSLOT]; // Strength per slot
  logic [`LSP_NSLOT-1:0] lnk_hit; // Link event names this slot
  logic [`LSP_NSLOT-1:0] cmd_hit; // Command names this slot
  logic [`LSP_NSLOT-1:0] conn_sel; // Slot that takes a new connection
  logic [`LSP_NSLOT-1:0] clr; // Clear strobe per slot
  logic found; // Command handle names a live link
  logic [`LSP_VALUE_W-1:0] sel_count; // Count of addressed link
  logic signed [`LSP_BYTE_W-1:0] sel_sample; // Sample of addressed link
  logic known_op; // Opcode is one we serve
  logic is_clear; // Opcode is the clear command
  logic [`LSP_STATUS_W-1:0] next_status; // Status for the reply
  logic [`LSP_VALUE_W-1:0] next_value; // Value for the reply
  logic [`LSP_BYTE_W-1:0] quality; // Derived link quality
  logic signed [`LSP_BYTE_W-1:0] offset; // Window offset in dB
  logic signed [`LSP_BYTE_W:0] diff; // Unsaturated offset

  // Signed 9-bit value clamped into one signed byte
  function automatic logic signed [`LSP_BYTE_W-1:0] sat8(input logic signed [`LSP_BYTE_W:0] v);
    // Limits are nine bits wide; cut to the byte on purpose
    if (v > `LSP_S8_MAX) begin
      return `LSP_BYTE_W'(`LSP_S8_MAX);
    end else if (v < `LSP_S8_MIN) begin
      return `LSP_BYTE_W'(`LSP_S8_MIN);
    end
    return v[`LSP_BYTE_W-1:0];
  endfunction : sat8

  // Slot matching for link events and for the command
  always_comb begin
    logic taken;
    taken = 1'b0;
    conn_sel = '0;
    for (int i = 0; i < `LSP_NSLOT; i++) begin
      lnk_hit[i] = used[i] && slot_handle[i] == LNK.handle;
      cmd_hit[i] = used[i] && slot_handle[i] == cmd_q.handle;
    end
    // Reconnect on a known handle reuses its slot, otherwise lowest free slot
    if (|lnk_hit) begin
      conn_sel = lnk_hit;
    end else begin
      for (int i = 0; i < `LSP_NSLOT; i++) begin
        if (!used[i] && !taken) begin
          conn_sel[i] = 1'b1;
          taken = 1'b1;
        end
      end
    end
  end

  // One slot per tracked link
  for (genvar g = 0; g < `LSP_NSLOT; g++) begin : g_slot
    lsp_slot u_slot (
      .clk(CLK),
      .rst(RST),
      .connect(LNK_VALID && LNK.kind == LSP_LNK_CONNECT && conn_sel[g]),
      .disconnect(LNK_VALID && LNK.kind == LSP_LNK_DISCONNECT && lnk_hit[g]),
      .handle_in(LNK.handle),
      .flush(LNK_VALID && LNK.kind == LSP_LNK_FLUSH && lnk_hit[g]),
      .ack(LNK_VALID && LNK.kind == LSP_LNK_ACK && lnk_hit[g]),
      .clear(clr[g]),
      .sample_we(LNK_VALID && LNK.kind == LSP_LNK_SAMPLE && lnk_hit[g]),
      .sample_in(LNK.sample),
      .used(used[g]),
      .handle(slot_handle[g]),
      .count(slot_count[g]),
      .sample(slot_sample[g])
    );
  end

  // Pick the addressed link's state; reserved handles never match
  always_comb begin
    found = 1'b0;
    sel_count = `LSP_MISS_ZERO;
    sel_sample = '0;
    for (int i = 0; i < `LSP_NSLOT; i++) begin
      if (cmd_hit[i] && cmd_q.handle <= `LSP_HANDLE_MAX) begin
        found = 1'b1;
        sel_count = slot_count[i];
        sel_sample = slot_sample[i];
      end
    end
  end

  // Quality falls with consecutive misses; zero misses is best
  always_comb begin
    if (sel_count > `LSP_QUAL_LIMIT) begin
      quality = '0;
    end else begin
      quality = `LSP_QUAL_BEST - (sel_count[`LSP_BYTE_W-1:0] << `LSP_QUAL_SHIFT);
    end
  end

  // Distance outside the reference window, zero inside it
  always_comb begin
    if (sel_sample > WIN_UPPER) begin
      diff = sel_sample - WIN_UPPER;
    end else if (sel_sample < WIN_LOWER) begin
      diff = sel_sample - WIN_LOWER;
    end else begin
      diff = '0;
    end
    offset = sat8(diff);
  end

  // Decode the opcode and form status and value
  always_comb begin
    known_op = cmd_q.ogf == `LSP_OGF_STATUS && (cmd_q.ocf == `LSP_OCF_READ_MISS ||
      cmd_q.ocf == `LSP_OCF_CLEAR_MISS || cmd_q.ocf == `LSP_OCF_QUALITY || cmd_q.ocf == `LSP_OCF_SIGNAL);
    is_clear = cmd_q.ogf == `LSP_OGF_STATUS && cmd_q.ocf == `LSP_OCF_CLEAR_MISS;
    next_value = '0;
    if (!known_op) begin
      next_status = `LSP_ST_UNK_CMD;
    end else if (!found) begin
      next_status = `LSP_ST_NO_LINK;
    end else begin
      next_status = `LSP_ST_OK;
      unique case (cmd_q.ocf)
        `LSP_OCF_READ_MISS: next_value = sel_count;
        `LSP_OCF_QUALITY: next_value = {{`LSP_BYTE_W{1'b0}}, quality};
        `LSP_OCF_SIGNAL: next_value = {{`LSP_BYTE_W{1'b0}}, offset};
        default: next_value = '0;
      endcase
    end
  end

  // Clear strobe only for a good clear command, so a bad handle touches nothing
  always_comb begin
    for (int i = 0; i < `LSP_NSLOT; i++) begin
      clr[i] = state == LSP_EXEC && is_clear && found && cmd_hit[i];
    end
  end

  assign CMD_READY = state == LSP_IDLE;
  assign EVT_VALID = state == LSP_RESP;

  // Engine: take, execute for one cycle, then offer the event unless EVT_MASK is set
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= LSP_IDLE;
    end else begin
      unique case (state)
        LSP_IDLE: if (CMD_VALID) begin
          state <= LSP_EXEC;
        end
        // A masked event still completes the command, just silently
        LSP_EXEC: state <= EVT_MASK ? LSP_IDLE : LSP_RESP;
        LSP_RESP: if (EVT_READY) begin
          state <= LSP_IDLE;
        end
      endcase
    end
  end

  // Command capture
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_q <= '0;
    end else if (CMD_VALID && CMD_READY) begin
      cmd_q <= CMD;
    end
  end

  // Event contents are frozen from execution until taken
  always_ff @(posedge CLK) begin
    if (RST) begin
      EVT <= '0;
    end else if (state == LSP_EXEC) begin
      EVT.ogf <= cmd_q.ogf;
      EVT.ocf <= cmd_q.ocf;
      EVT.status <= next_status;
      EVT.handle <= cmd_q.handle;
      EVT.value <= next_value;
    end
  end

  a_read_value: assert property (@(posedge CLK) disable iff (RST)
    (state == LSP_EXEC && found && cmd_q.ogf == `LSP_OGF_STATUS && cmd_q.ocf == `LSP_OCF_READ_MISS)
    |=> EVT.value == $past(sel_count) && EVT.status == `LSP_ST_OK)
    else $error("read reply does not carry the count");
  a_handle_reserved: assert property (@(posedge CLK) disable iff (RST)
    (state == LSP_EXEC && cmd_q.handle > `LSP_HANDLE_MAX) |=> EVT.status != `LSP_ST_OK)
    else $error("reserved handle reported success");
  a_echo_handle: assert property (@(posedge CLK) disable iff (RST)
    state == LSP_EXEC |=> EVT.handle == $past(cmd_q.handle))
    else $error("reply handle differs from command");
  a_evt_hold: assert property (@(posedge CLK) disable iff (RST)
    (EVT_VALID && !EVT_READY) |=> EVT_VALID && $stable(EVT))
    else $error("event dropped or changed before taken");
  a_evt_raise: assert property (@(posedge CLK) disable iff (RST)
    (CMD_VALID && CMD_READY) ##1 !EVT_MASK |=> EVT_VALID)
    else $error("unmasked command gave no event");
  a_mask_quiet: assert property (@(posedge CLK) disable iff (RST)
    (state == LSP_EXEC && EVT_MASK) |=> !EVT_VALID && CMD_READY)
    else $error("masked command raised an event");
  a_window_zero: assert property (@(posedge CLK) disable iff (RST)
    (state == LSP_EXEC && found && cmd_q.ocf == `LSP_OCF_SIGNAL && cmd_q.ogf == `LSP_OGF_STATUS
      && sel_sample <= WIN_UPPER && sel_sample >= WIN_LOWER) |=> EVT.value == '0)
    else $error("inside window did not read zero");
  a_above_pos: assert property (@(posedge CLK) disable iff (RST)
    (state == LSP_EXEC && found && cmd_q.ocf == `LSP_OCF_SIGNAL && cmd_q.ogf == `LSP_OGF_STATUS
      && sel_sample > WIN_UPPER) |=> !EVT.value[`LSP_BYTE_W-1] && EVT.value != '0)
    else $error("above window not positive");
  a_clear_scope: assert property (@(posedge CLK) disable iff (RST)
    (state == LSP_EXEC && !found) |-> clr == '0)
    else $error("bad handle touched a counter");
endmodule : lsp_status_cmds

// ### test/lsp_host_model.sv
`timescale 1ns/10ps
module lsp_host_model (
  // Clock
  input wire logic clk,
  // Command side
  output logic cmd_valid,
  input wire logic cmd_ready,
  output lsp_pkg::lsp_cmd_s cmd,
  // Event side
  input wire logic evt_valid,
  output logic evt_ready,
  input wire lsp_pkg::lsp_evt_s evt
);
  import lsp_pkg::*;
  // Host idle at start
  initial begin
    cmd_valid = 1'b0;
    evt_ready = 1'b0;
    cmd = '0;
  end
  // One command; stall delays the event accept to test that it stands
  task automatic run(input lsp_cmd_s c, input int stall, input bit masked, output lsp_evt_s e, output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    // Offer held until the take edge
    do begin @(negedge clk); n++; end while (!cmd_ready && n < 20);
    // Never taken: report failure, the bench closes the run
    if (!cmd_ready) return;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // Released lines show no stale value
    cmd <= ~c;
    n = 0;
    do begin @(negedge clk); n++; end while (!evt_valid && n < (masked ? 4 : 20));
    // Masked: no event, engine free again
    if (masked) begin
      ok = !evt_valid && cmd_ready;
      return;
    end
    if (!evt_valid) return;
    repeat (stall) @(posedge clk);
    @(posedge clk);
    evt_ready <= 1'b1;
    @(negedge clk);
    e = evt;
    ok = evt_valid;
    @(posedge clk);
    evt_ready <= 1'b0;
  endtask : run
endmodule : lsp_host_model

// ### test/tb_lsp_status_cmds.sv
`timescale 1ns/10ps
`include "lsp_cfg.svh"
module tb_lsp_status_cmds;
  import lsp_pkg::*;
  // Design inputs
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic EVT_MASK = 1'b0;
  logic LNK_VALID = 1'b0;
  lsp_lnk_s LNK = '0;
  logic signed [7:0] WIN_UPPER = 8'sh0a;
  logic signed [7:0] WIN_LOWER = 8'shf6;
  // Handshake nets
  logic CMD_VALID, CMD_READY, EVT_VALID, EVT_READY;
  lsp_cmd_s CMD;
  lsp_evt_s EVT;
  int n_mismatch = 0;
  int checks = 0;
  // 50 MHz
  always #10 CLK = ~CLK;
  lsp_status_cmds u_lsp_status_cmds (.CLK(CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .CMD(CMD), .EVT_VALID(EVT_VALID), .EVT_READY(EVT_READY), .EVT(EVT), .EVT_MASK(EVT_MASK),
    .LNK_VALID(LNK_VALID), .LNK(LNK), .WIN_UPPER(WIN_UPPER), .WIN_LOWER(WIN_LOWER));
  lsp_host_model u_lsp_host_model (.clk(CLK), .cmd_valid(CMD_VALID), .cmd_ready(CMD_READY), .cmd(CMD),
    .evt_valid(EVT_VALID), .evt_ready(EVT_READY), .evt(EVT));
  // Verdict, the single exit
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // Compare with four-state equality
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle link event pulse
  task automatic lnk(input lsp_lnk_e k, input logic [11:0] h, input logic signed [7:0] s);
    @(posedge CLK);
    LNK_VALID <= 1'b1;
    LNK <= '{k, h, s};
    @(posedge CLK);
    LNK_VALID <= 1'b0;
  endtask : lnk
  // Issue a command and check the event; group and opcode come from the caller
  task automatic expect_evt(input logic [5:0] ogf, input logic [9:0] ocf, input logic [11:0] h,
                            input logic [7:0] st, input logic [15:0] val);
    lsp_evt_s e;
    bit ok;
    u_lsp_host_model.run('{ogf, ocf, h}, $urandom_range(0, 3), 1'b0, e, ok);
    chk(32'(ok), 32'h1);
    if (!ok) begin
      tally_and_finish();
    end
    chk(e.status, st);
    chk(e.handle, h);
    chk({e.ogf, e.ocf}, {ogf, ocf});
    chk(e.value, val);
  endtask : expect_evt
  // Quality: 255 less 16 per miss, floor 0
  function automatic logic [15:0] qual(input int c);
    return (c > 15) ? 16'h0000 : 16'(255 - 16 * c);
  endfunction : qual
  // Offset from the window, saturated to a signed byte
  function automatic logic [15:0] sig(input int s, input int up, input int lo);
    int d;
    d = (s > up) ? s - up : (s < lo) ? s - lo : 0;
    d = (d > 127) ? 127 : (d < -128) ? -128 : d;
    return {8'h00, 8'(d)};
  endfunction : sig
  // Main sequence
  initial begin
    int cs[6];
    int s, k;
    lsp_evt_s e;
    bit ok;
    cs = '{10, 11, -10, -11, 127, -128};
    void'($urandom(32560));
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    // Count, quality, ack, clear, reconnect
    lnk(LSP_LNK_CONNECT, 12'h123, 8'sh00);
    repeat (3) lnk(LSP_LNK_FLUSH, 12'h123, 8'sh00);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'h123, `LSP_ST_OK, 16'h0003);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_QUALITY, 12'h123, `LSP_ST_OK, qual(3));
    lnk(LSP_LNK_ACK, 12'h123, 8'sh00);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'h123, `LSP_ST_OK, 16'h0000);
    repeat (2) lnk(LSP_LNK_FLUSH, 12'h123, 8'sh00);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_CLEAR_MISS, 12'h123, `LSP_ST_OK, 16'h0000);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'h123, `LSP_ST_OK, 16'h0000);
    lnk(LSP_LNK_FLUSH, 12'h123, 8'sh00);
    lnk(LSP_LNK_CONNECT, 12'h123, 8'sh00);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'h123, `LSP_ST_OK, 16'h0000);
    $display("test counters done");
    // Bad handles and opcodes leave counts alone
    lnk(LSP_LNK_FLUSH, 12'h123, 8'sh00);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_CLEAR_MISS, 12'h456, `LSP_ST_NO_LINK, 16'h0000);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'hf00, `LSP_ST_NO_LINK, 16'h0000);
    expect_evt(6'h06, `LSP_OCF_READ_MISS, 12'h123, `LSP_ST_UNK_CMD, 16'h0000);
    expect_evt(`LSP_OGF_STATUS, 10'h004, 12'h123, `LSP_ST_UNK_CMD, 16'h0000);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'h123, `LSP_ST_OK, 16'h0001);
    lnk(LSP_LNK_CONNECT, 12'heff, 8'sh00);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'heff, `LSP_ST_OK, 16'h0000);
    // Dropped link is no longer known, then comes back
    lnk(LSP_LNK_DISCONNECT, 12'heff, 8'sh00);
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_QUALITY, 12'heff, `LSP_ST_NO_LINK, 16'h0000);
    lnk(LSP_LNK_CONNECT, 12'heff, 8'sh00);
    $display("test refusals done");
    // Strength: window edges, extremes, then random
    @(posedge CLK);
    WIN_UPPER <= 8'($urandom_range(0, 40));
    WIN_LOWER <= -8'($urandom_range(0, 40));
    // Let the new window land before corner values are built from it
    @(posedge CLK);
    for (int i = 0; i < 26; i++) begin
      s = (i < 6) ? cs[i] + ((i < 4) ? int'(WIN_UPPER) - 10 : 0) : $urandom_range(0, 255) - 128;
      if (i == 2 || i == 3) s = cs[i] + 10 + int'(WIN_LOWER);
      lnk(LSP_LNK_SAMPLE, 12'heff, 8'(s));
      expect_evt(`LSP_OGF_STATUS, `LSP_OCF_SIGNAL, 12'heff, `LSP_ST_OK,
                 sig(s, int'(WIN_UPPER), int'(WIN_LOWER)));
    end
    $display("test strength done");
    // Random miss runs on a fresh link
    for (int i = 0; i < 10; i++) begin
      k = $urandom_range(0, 20);
      lnk(LSP_LNK_CONNECT, 12'h123, 8'sh00);
      repeat (k) lnk(LSP_LNK_FLUSH, 12'h123, 8'sh00);
      expect_evt(`LSP_OGF_STATUS, `LSP_OCF_QUALITY, 12'h123, `LSP_ST_OK, qual(k));
      expect_evt(`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'h123, `LSP_ST_OK, 16'(k));
    end
    $display("test random runs done");
    // Masked event: none raised, engine free again
    @(posedge CLK);
    EVT_MASK <= 1'b1;
    u_lsp_host_model.run('{`LSP_OGF_STATUS, `LSP_OCF_READ_MISS, 12'h123}, 0, 1'b1, e, ok);
    chk(32'(ok), 32'h1);
    @(posedge CLK);
    EVT_MASK <= 1'b0;
    expect_evt(`LSP_OGF_STATUS, `LSP_OCF_QUALITY, 12'h123, `LSP_ST_OK, qual(k));
    $display("test mask done");
    tally_and_finish();
  end
endmodule : tb_lsp_status_cmds
